// ===== hdl/dsc_pkg.sv
// Package: constants and carriers for the serial command decoder
package dsc_pkg;
    localparam int WORD_BITS = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 12;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int CTL_FLAG_BIT = 13;
    localparam int CTL_MID_BIT = 12;
    localparam int CTL_WIPE_BIT = 11;
    localparam int SEL_PLO_BIT = 9;
    localparam int SEL_PHI_BIT = 10;
    localparam int SEL_FREQ_BIT = 11;
    localparam logic [1:0] TOP_SYNC = 2'h2;
    localparam logic [1:0] TOP_POWER = 2'h3;
    localparam logic [3:0] CMD_PHASE_WRITE = 4'h0;
    localparam logic [3:0] CMD_PHASE_DEFER = 4'h1;
    localparam logic [3:0] CMD_FREQ_WRITE = 4'h2;
    localparam logic [3:0] CMD_FREQ_DEFER = 4'h3;
    localparam logic [3:0] CMD_PSEL = 4'h4;
    localparam logic [3:0] CMD_FSEL = 4'h5;
    localparam logic [3:0] CMD_BOTH_SEL = 4'h6;
    localparam logic [3:0] CMD_TEST = 4'h7;
    localparam int SYNC_LATENCY = 2;
    localparam logic [4:0] BIT_COUNT_LAST = 5'h10;
    localparam logic [31:0] FREQ_RESET = 32'h0;
    localparam logic [11:0] PHASE_RESET = 12'h0;
    localparam logic [7:0] HOLD_RESET = 8'h0;

    // One decoded load request
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] dest;
        logic [7:0] data;
    } dsc_word_s;

    // Selection carrier
    typedef struct packed {
        logic phaseHi;
        logic phaseLo;
        logic freq;
    } dsc_sel_s;
endpackage : dsc_pkg

// ===== hdl/dsc_decoder.sv
// Serial control word decoder for a direct digital synthesizer
// Operation
// (R1) Code 0001 stores data in phase holding byte
// (R2) Code 0000 writes held+data to phase register
// (R3) Code 0011 stores data in frequency holding byte
// (R4) Code 0010 writes held+data to frequency half
// (R5) Code 0100 takes D9/D10 as phase select
// (R6) Code 0101 takes D11 as frequency select
// (R7) Code 0110 updates all select bits together
// (R8) Host never issues reserved test code 0111
// (R9) Top bits 10: D13 sets sync flag
// (R10) Sync set adds two master clock latency
// (R11) Sync clear loads and samples without alignment
// (R12) D12 chooses select bits or select pins
// (R13) Top bits 11: D13 sleeps or wakes
// (R14) D12 in power word zeroes accumulator
// (R15) D11 clears sync and source flags, self-clearing
// (R16) Host zeroes top nibble of phase high
// (R17) Frequency word built from four byte slices
// (R18) Word: command, address, then eight data bits
// (R19) Frame low, sixteen falling edges, frame high
// (R20) Addresses 0-7 frequency, 8-15 phase bytes
// (R21) Select pins sampled on master clock edge
// (R22) Holding byte kept until next defer command
// (R23) Flags, selects and sleep reset to zero
module dsc_decoder #(
    parameter int FREQ_BITS = 32,
    parameter int PHASE_BITS = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial write port
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic frame_strobe_n,
    // Select pins
    input wire logic freq_word_choice,
    input wire logic phase_choice_lo,
    input wire logic phase_choice_hi,
    // Loaded registers
    output logic [FREQ_BITS-1:0] freq_word_a,
    output logic [FREQ_BITS-1:0] freq_word_b,
    output logic [PHASE_BITS-1:0] phase_offset_zero,
    output logic [PHASE_BITS-1:0] phase_offset_one,
    output logic [PHASE_BITS-1:0] phase_offset_two,
    output logic [PHASE_BITS-1:0] phase_offset_three,
    // Control state
    output dsc_pkg::dsc_sel_s activeSel,
    output logic syncFlag,
    output logic choice_origin_flag,
    output logic sleepMode,
    output logic accumZeroPulse,
    output logic wordDone
);
    import dsc_pkg::*;

    // Elaboration checks; the byte slicing below is fixed to these widths
    if (FREQ_BITS != 32 || PHASE_BITS != 12) begin : gBadWidths
        $error("dsc_decoder: only 32-bit frequency and 12-bit phase supported");
    end
    if (SYNC_LATENCY < 2) begin : gBadLatency
        $error("dsc_decoder: sync delay line needs at least two stages");
    end

    // Two-stage synchronisers for all asynchronous pins
    logic [1:0] sclkSync_q;
    logic [1:0] sdatSync_q;
    logic [1:0] frmSync_q;
    logic [1:0] fselSync_q;
    logic [1:0] plSync_q;
    logic [1:0] phSync_q;
    // Edge register behind the serial clock synchroniser
    logic sclkPrev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkSync_q <= 2'h3;
            sdatSync_q <= 2'h0;
            frmSync_q <= 2'h3;
            fselSync_q <= 2'h0;
            plSync_q <= 2'h0;
            phSync_q <= 2'h0;
            sclkPrev_q <= 1'b1;
        end else begin
            sclkSync_q <= {sclkSync_q[0], serial_clk};
            sdatSync_q <= {sdatSync_q[0], serial_in};
            frmSync_q <= {frmSync_q[0], frame_strobe_n};
            fselSync_q <= {fselSync_q[0], freq_word_choice}; // R21
            plSync_q <= {plSync_q[0], phase_choice_lo};
            phSync_q <= {phSync_q[0], phase_choice_hi};
            sclkPrev_q <= sclkSync_q[1];
        end
    end

    logic sclkFall;
    logic frameActive;
    assign sclkFall = sclkPrev_q & ~sclkSync_q[1];
    assign frameActive = ~frmSync_q[1];

    // Shift register; 16 falling edges inside a frame make one word
    logic [WORD_BITS-1:0] shift_q;
    logic [4:0] bitCnt_q;
    logic wordValid_q;
    logic [WORD_BITS-1:0] word_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            bitCnt_q <= 5'h0;
            wordValid_q <= 1'b0;
            word_q <= '0;
        end else begin
            wordValid_q <= 1'b0;
            if (!frameActive) begin
                bitCnt_q <= 5'h0; // R19
            end else if (sclkFall && bitCnt_q != BIT_COUNT_LAST) begin
                shift_q <= {shift_q[WORD_BITS-2:0], sdatSync_q[1]};
                bitCnt_q <= bitCnt_q + 5'h1;
                // Extra edges beyond sixteen are ignored until the frame ends
                if (bitCnt_q == BIT_COUNT_LAST - 5'h1) begin
                    word_q <= {shift_q[WORD_BITS-2:0], sdatSync_q[1]}; // R19
                    wordValid_q <= 1'b1;
                end
            end
        end
    end

    // Sync flag delays the apply stage by two master cycles
    logic [SYNC_LATENCY-1:0] dlyValid_q;
    logic [WORD_BITS-1:0] dlyWord_q [SYNC_LATENCY];
    logic applyValid;
    logic [WORD_BITS-1:0] applyWord;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dlyValid_q <= '0;
            for (int i = 0; i < SYNC_LATENCY; i++) begin
                dlyWord_q[i] <= '0;
            end
        end else begin
            dlyValid_q <= {dlyValid_q[SYNC_LATENCY-2:0], wordValid_q & syncFlag}; // R10
            // Word copy runs freely; only the valid bits gate its use
            dlyWord_q[0] <= word_q;
            for (int i = 1; i < SYNC_LATENCY; i++) begin
                dlyWord_q[i] <= dlyWord_q[i-1];
            end
        end
    end

    // Unsynchronised mode applies at once; delayed words finish even if the flag drops
    assign applyValid = (wordValid_q & ~syncFlag) | dlyValid_q[SYNC_LATENCY-1]; // R11
    assign applyWord = dlyValid_q[SYNC_LATENCY-1] ? dlyWord_q[SYNC_LATENCY-1] : word_q;

    dsc_word_s cur;
    assign cur = applyWord; // R18

    function automatic logic [7:0] byteSlot(input logic [31:0] w, input logic [1:0] idx);
        byteSlot = w[idx*8 +: 8];
    endfunction : byteSlot

    // One decode for both select commands so the combined one cannot drift
    function automatic logic selCmd(input logic [3:0] cmd, input logic [3:0] own);
        selCmd = (cmd == own) || (cmd == CMD_BOTH_SEL);
    endfunction : selCmd

    // Holding bytes for phase and frequency
    logic [7:0] phaseHold_q;
    logic [7:0] freqHold_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseHold_q <= HOLD_RESET;
            freqHold_q <= HOLD_RESET;
        end else if (applyValid) begin
            if (cur.cmd == CMD_PHASE_DEFER) begin
                phaseHold_q <= cur.data; // R1 R22
            end
            if (cur.cmd == CMD_FREQ_DEFER) begin
                freqHold_q <= cur.data; // R3 R22
            end
        end
    end

    // Frequency registers; address picks 16-bit half, held byte is high byte
    logic [15:0] combined;
    logic [31:0] freqSel;
    assign combined = {freqHold_q, cur.data};
    assign freqSel = cur.dest[2] ? freq_word_b : freq_word_a;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_word_a <= FREQ_RESET;
            freq_word_b <= FREQ_RESET;
        end else if (applyValid && cur.cmd == CMD_FREQ_WRITE && !cur.dest[3]) begin // R20
            // Four byte slices: low/high of lower half, low/high of upper half
            if (cur.dest[1]) begin
                if (cur.dest[2]) begin
                    freq_word_b <= {combined, byteSlot(freqSel, 2'h1), byteSlot(freqSel, 2'h0)}; // R4 R17
                end else begin
                    freq_word_a <= {combined, byteSlot(freqSel, 2'h1), byteSlot(freqSel, 2'h0)}; // R4 R17
                end
            end else if (cur.dest[2]) begin
                freq_word_b <= {byteSlot(freqSel, 2'h3), byteSlot(freqSel, 2'h2), combined}; // R4 R17
            end else begin
                freq_word_a <= {byteSlot(freqSel, 2'h3), byteSlot(freqSel, 2'h2), combined}; // R4 R17
            end
        end
    end

    // Phase registers; upper nibble of held byte dropped, host keeps it zero
    logic [11:0] phaseVal;
    assign phaseVal = {phaseHold_q[3:0], cur.data}; // R16

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_offset_zero <= PHASE_RESET;
            phase_offset_one <= PHASE_RESET;
            phase_offset_two <= PHASE_RESET;
            phase_offset_three <= PHASE_RESET;
        end else if (applyValid && cur.cmd == CMD_PHASE_WRITE && cur.dest[3]) begin // R20
            unique case (cur.dest[2:1])
                2'h0: phase_offset_zero <= phaseVal; // R2
                2'h1: phase_offset_one <= phaseVal; // R2
                2'h2: phase_offset_two <= phaseVal; // R2
                2'h3: phase_offset_three <= phaseVal; // R2
            endcase
        end
    end

    // Control flags, select bits and sleep
    dsc_sel_s selBits_q;
    logic [1:0] top;
    assign top = applyWord[CMD_MSB -: 2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncFlag <= 1'b0; // R23
            choice_origin_flag <= 1'b0;
            sleepMode <= 1'b0;
            selBits_q <= '0;
            accumZeroPulse <= 1'b0;
        end else begin
            accumZeroPulse <= 1'b0;
            if (applyValid) begin
                if (top == TOP_SYNC) begin
                    syncFlag <= applyWord[CTL_FLAG_BIT]; // R9
                    choice_origin_flag <= applyWord[CTL_MID_BIT]; // R12
                end else if (top == TOP_POWER) begin
                    sleepMode <= applyWord[CTL_FLAG_BIT]; // R13
                    accumZeroPulse <= applyWord[CTL_MID_BIT]; // R14
                    // Wipe is a one-shot action, never stored
                    if (applyWord[CTL_WIPE_BIT]) begin
                        syncFlag <= 1'b0; // R15
                        choice_origin_flag <= 1'b0; // R15
                    end
                end
                // Reserved test code 0111 is ignored here
                if (selCmd(cur.cmd, CMD_PSEL)) begin
                    selBits_q.phaseLo <= applyWord[SEL_PLO_BIT]; // R5 R7
                    selBits_q.phaseHi <= applyWord[SEL_PHI_BIT]; // R5 R7
                end
                if (selCmd(cur.cmd, CMD_FSEL)) begin
                    selBits_q.freq <= applyWord[SEL_FREQ_BIT]; // R6 R7
                end
            end
        end
    end

    // Selection applied on master edge; in sync mode pins take the added delay
    dsc_sel_s pinSel;
    dsc_sel_s pinDly_q [SYNC_LATENCY];
    assign pinSel = '{phaseHi: phSync_q[1], phaseLo: plSync_q[1], freq: fselSync_q[1]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SYNC_LATENCY; i++) begin
                pinDly_q[i] <= '0;
            end
            activeSel <= '0;
        end else begin
            pinDly_q[0] <= pinSel;
            for (int i = 1; i < SYNC_LATENCY; i++) begin
                pinDly_q[i] <= pinDly_q[i-1];
            end
            if (choice_origin_flag) begin
                activeSel <= selBits_q; // R5 R6 R12
            end else begin
                activeSel <= syncFlag ? pinDly_q[SYNC_LATENCY-1] : pinSel; // R10 R11 R21
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wordDone <= 1'b0;
        end else begin
            // Rises on the same edge as the load, one cycle after applyValid, so observers see settled registers
            wordDone <= applyValid;
        end
    end
endmodule : dsc_decoder

// ===== tb/dsc_decoder_checker.sv
// Port-level assertions for the serial command decoder
module dsc_decoder_checker #(
    parameter int FREQ_BITS = 32,
    parameter int PHASE_BITS = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Select pins
    input wire logic freq_word_choice,
    input wire logic phase_choice_lo,
    input wire logic phase_choice_hi,
    // Watched outputs
    input wire logic [FREQ_BITS-1:0] freq_word_b,
    input wire logic [PHASE_BITS-1:0] phase_offset_three,
    input wire dsc_pkg::dsc_sel_s activeSel,
    input wire logic syncFlag,
    input wire logic choice_origin_flag,
    input wire logic sleepMode,
    input wire logic accumZeroPulse,
    input wire logic wordDone
);
    timeunit 1ns;
    timeprecision 100ps;
    import dsc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_done; wordDone |=> !wordDone; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_zero; accumZeroPulse |=> !accumZeroPulse; endproperty
    a_zero: assert property (p_zero) else $error("zero pulse too long");
    property p_freq; $changed(freq_word_b) |-> wordDone; endproperty
    a_freq: assert property (p_freq) else $error("freq load without word");
    property p_phase; $changed(phase_offset_three) |-> wordDone; endproperty
    a_phase: assert property (p_phase) else $error("phase load without word");
    property p_flags; $changed({syncFlag, choice_origin_flag}) |-> wordDone; endproperty
    a_flags: assert property (p_flags) else $error("flag change without word");
    property p_sleep; $changed(sleepMode) |-> wordDone; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep change without word");
    property p_reset; $rose(rst_n) |-> {activeSel, syncFlag, choice_origin_flag, sleepMode} == 6'h0; endproperty
    a_reset: assert property (p_reset) else $error("state not zero after reset");
    // Pins need time to cross the synchronisers before they show
    property p_pins; (!choice_origin_flag && $stable({freq_word_choice, phase_choice_lo, phase_choice_hi}))[*8]
        |-> activeSel == {phase_choice_hi, phase_choice_lo, freq_word_choice}; endproperty
    a_pins: assert property (p_pins) else $error("pin select not followed");
endmodule : dsc_decoder_checker

// ===== tb/dsc_host_model.sv
// Host model driving the framed serial write port
module dsc_host_model (
    // Serial write port
    output logic serial_clk,
    output logic serial_in,
    output logic frame_strobe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_clk = 1'b1;
        serial_in = 1'b0;
        frame_strobe_n = 1'b1;
    end
    // Clock idles high outside frames; data idles inverted so stale bits never match
    task automatic send(input logic [15:0] w);
        frame_strobe_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in = w[i];
            #16 serial_clk = 1'b0;
            #16 serial_clk = 1'b1;
        end
        frame_strobe_n = 1'b1;
        serial_in = ~w[0];
        #32;
    endtask : send
endmodule : dsc_host_model

// ===== tb/test_dsc_decoder.sv
// Self-checking bench for the serial command decoder
module test_dsc_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    import dsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fPin = 1'b0;
    logic pLo = 1'b0;
    logic pHi = 1'b0;
    logic sClk, sIn, frameN, syncF, originF, sleepF, zeroP, done, doneSeen;
    logic [31:0] fw [2];
    logic [11:0] ph [4];
    logic [31:0] expF [2] = '{default: 32'h0};
    logic [11:0] expP [4] = '{default: 12'h0};
    logic [7:0] holdF = 8'h0;
    logic [7:0] holdP = 8'h0;
    dsc_sel_s sel;
    dsc_sel_s expS = '0;
    int errors = 0, comparisons = 0, cycles = 0, lat = 0, lastLat = 0, lat0 = 0, zeros = 0;
    always #2 clk = ~clk;
    dsc_host_model host (.serial_clk(sClk), .serial_in(sIn), .frame_strobe_n(frameN));
    dsc_decoder dut (.clk(clk), .rst_n(rst_n), .serial_clk(sClk), .serial_in(sIn), .frame_strobe_n(frameN),
        .freq_word_choice(fPin), .phase_choice_lo(pLo), .phase_choice_hi(pHi), .freq_word_a(fw[0]),
        .freq_word_b(fw[1]), .phase_offset_zero(ph[0]), .phase_offset_one(ph[1]), .phase_offset_two(ph[2]),
        .phase_offset_three(ph[3]), .activeSel(sel), .syncFlag(syncF), .choice_origin_flag(originF),
        .sleepMode(sleepF), .accumZeroPulse(zeroP), .wordDone(done));
    // Latency counted from the last serial fall to the done pulse
    always @(negedge sClk) lat = 0;
    always @(posedge clk) begin
        cycles++;
        lat++;
        if (done === 1'b1) begin
            doneSeen = 1'b1;
            lastLat = lat;
        end
        if (zeroP === 1'b1) zeros++;
        if (cycles == 30000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic void model(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
        case (c)
            CMD_PHASE_DEFER: holdP = d;
            CMD_FREQ_DEFER: holdF = d;
            CMD_PHASE_WRITE: if (a[3]) expP[a[2:1]] = {holdP[3:0], d};
            CMD_FREQ_WRITE: if (!a[3]) expF[a[2]][a[1]*16 +: 16] = {holdF, d};
            CMD_PSEL: {expS.phaseHi, expS.phaseLo} = a[2:1];
            CMD_FSEL: expS.freq = a[3];
            CMD_BOTH_SEL: expS = {a[2:1], a[3]};
            default: ;
        endcase
    endfunction : model
    task automatic put(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
        doneSeen = 1'b0;
        host.send({c, a, d});
        for (int i = 0; i < 40 && !doneSeen; i++) @(posedge clk);
        @(posedge clk);
        #1;
        model(c, a, d);
        chk("wordDone", 32'h1, doneSeen);
        for (int i = 0; i < 4; i++) chk("phase", expP[i], ph[i]);
        for (int i = 0; i < 2; i++) chk("freq", expF[i], fw[i]);
    endtask : put
    initial begin
        void'($urandom(23268));
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("flags", 32'h0, {sel, syncF, originF, sleepF});
        // Every address with both codes, so mismatched halves must be ignored
        for (int k = 0; k < 16; k++) begin
            put(CMD_FREQ_DEFER, k[3:0], 8'($urandom));
            put(CMD_PSEL, 4'($urandom), 8'h00);
            put(CMD_FREQ_WRITE, k[3:0], 8'($urandom));
            put(CMD_PHASE_DEFER, 4'h0, 8'($urandom) & 8'h0f);
            put(CMD_PHASE_WRITE, k[3:0], 8'($urandom));
        end
        for (int k = 0; k < 4; k++) begin
            {pHi, pLo, fPin} = 3'($urandom);
            repeat (10) @(posedge clk);
            #1;
            chk("pinSel", {pHi, pLo, fPin}, sel);
        end
        lat0 = lastLat;
        put(4'hb, 4'h0, 8'h00);
        chk("flags", 32'h3, {syncF, originF});
        for (int k = 0; k < 9; k++) begin
            {pHi, pLo, fPin} = 3'($urandom);
            put(CMD_BOTH_SEL - 4'(k % 3), 4'($urandom), 8'h00);
            repeat (4) @(posedge clk);
            #1;
            chk("bitSel", expS, sel);
            chk("latency", lat0 + 2, lastLat);
        end
        put(4'hf, 4'h8, 8'h00);
        chk("sleepWipe", 32'h4, {sleepF, syncF, originF});
        chk("zeroPulses", 32'h1, zeros);
        put(4'hc, 4'h0, 8'h00);
        put(4'ha, 4'h0, 8'h00);
        chk("sleepSync", 32'h2, {sleepF, syncF, originF});
        chk("zeroPulses", 32'h1, zeros);
        {pHi, pLo, fPin} = 3'($urandom);
        repeat (10) @(posedge clk);
        #1;
        chk("pinSelSync", {pHi, pLo, fPin}, sel);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("flags", 32'h0, {sel, syncF, originF, sleepF});
        end_of_test();
    end
endmodule : test_dsc_decoder

bind dsc_decoder dsc_decoder_checker #(.FREQ_BITS(FREQ_BITS), .PHASE_BITS(PHASE_BITS)) chkr (.clk(clk),
    .rst_n(rst_n), .freq_word_choice(freq_word_choice), .phase_choice_lo(phase_choice_lo),
    .phase_choice_hi(phase_choice_hi), .freq_word_b(freq_word_b), .phase_offset_three(phase_offset_three),
    .activeSel(activeSel), .syncFlag(syncFlag), .choice_origin_flag(choice_origin_flag), .sleepMode(sleepMode),
    .accumZeroPulse(accumZeroPulse), .wordDone(wordDone));
